// ### lbg_defs.vh
// Register indices, field positions, reset values and timing constants of the gain-control block.
`ifndef LBG_DEFS_VH
`define LBG_DEFS_VH

// Register indices; the AXI byte address is four times the index.
`define LBG_IDX_COMB        6'h19
`define LBG_IDX_LIM_A       6'h1b
`define LBG_IDX_LIM_B       6'h1c
`define LBG_IDX_BOP_A       6'h1d
`define LBG_IDX_BOP_B       6'h1e
`define LBG_IDX_BOP_C       6'h1f
`define LBG_IDX_BOP_D       6'h20
`define LBG_IDX_STAT        6'h3c

// Reset values.
`define LBG_RST_COMB        8'h00
`define LBG_RST_LIM_A       8'h22
`define LBG_RST_LIM_B       8'h32
`define LBG_RST_BOP_A       8'h40
`define LBG_RST_BOP_B       8'h32
`define LBG_RST_BOP_C       8'h02
`define LBG_RST_BOP_D       8'h06

// Writable bit masks; reserved bits read as zero.
`define LBG_MSK_COMB        8'h20
`define LBG_MSK_LIM_A       8'h3f
`define LBG_MSK_LIM_B       8'hff
`define LBG_MSK_BOP_A       8'hfb
`define LBG_MSK_BOP_B       8'hff
`define LBG_MSK_BOP_C       8'hfe
`define LBG_MSK_BOP_D       8'hfe

// Field positions.
`define LBG_BIT_COMB_MODE   5
`define LBG_BIT_PEAK_LIMIT_ENABLE      0
`define LBG_BIT_LIM_DHYS    5
`define LBG_BIT_LIM_PAUSE   7
`define LBG_BIT_BROWNOUT_GUARD_ENABLE      0
`define LBG_BIT_BROWNOUT_LEVEL0_SHUTDOWN    1
`define LBG_BIT_HOLD_CLR    7

// Code limits.
`define LBG_ATK_CODE_MAX    4'hc
`define LBG_RLS_CODE_MAX    4'hc
`define LBG_DHR_CODE_MAX    5'h10
`define LBG_DHR_CODE_ZERO   5'h08
`define LBG_CAP_CODE_MAX    7'h2e

// Attenuation unit is 1/16 dB; 96 units make one halving of amplitude.
`define LBG_UNITS_PER_DB    16
`define LBG_UNITS_PER_6DB   96
`define LBG_UNITS_PER_FRAC  12
`define LBG_LIM_ATK_UNITS   2

// Timing: one tick is 2.5 us.
`define LBG_CLK_NS          20
`define LBG_TICK_NS         2500
`define LBG_TICK_CYCLES     ((`LBG_TICK_NS + `LBG_CLK_NS - 1) / `LBG_CLK_NS)
`define LBG_TICKS_PER_MS    (1000000 / `LBG_TICK_NS)
`define LBG_TICKS_PER_US10  (10000 / `LBG_TICK_NS)
`define LBG_RLS_TICKS_BASE  (4 * `LBG_TICKS_PER_MS / `LBG_UNITS_PER_DB)

// AXI responses.
`define LBG_RESP_OKAY       2'b00
`define LBG_RESP_SLVERR     2'b10

`endif

// ### lbg_gain_ctrl.v
// Limiter and brownout gain control with AXI4-Lite registers and a buffered audio path.
`timescale 1ns/1ns
`default_nettype none
`include "lbg_defs.vh"

module lbg_gain_ctrl #(
  parameter DW                = 24,
  parameter TICK_CYCLES       = `LBG_TICK_CYCLES,
  parameter BOP_HOLD_TICKS    = 4000,
  parameter BOP_HOLD_INFINITE = 0,
  parameter BOP_RLS_TICKS     = 4000
) (
  input  wire          mclk_i,
  input  wire          sys_rst_i,
  input  wire          s_axi_awvalid,
  output wire          s_axi_awready,
  input  wire [7:0]    s_axi_awaddr,
  input  wire          s_axi_wvalid,
  output wire          s_axi_wready,
  input  wire [31:0]   s_axi_wdata,
  input  wire [3:0]    s_axi_wstrb,
  output reg           s_axi_bvalid,
  input  wire          s_axi_bready,
  output reg  [1:0]    s_axi_bresp,
  input  wire          s_axi_arvalid,
  output wire          s_axi_arready,
  input  wire [7:0]    s_axi_araddr,
  output reg           s_axi_rvalid,
  input  wire          s_axi_rready,
  output reg  [31:0]   s_axi_rdata,
  output reg  [1:0]    s_axi_rresp,
  input  wire          bop_level3_i,
  input  wire          bop_level0_i,
  input  wire [DW-2:0] supply_peak_i,
  input  wire          in_valid_i,
  output wire          in_ready_o,
  input  wire [DW-1:0] in_data_i,
  output wire          out_valid_o,
  input  wire          out_ready_i,
  output wire [DW-1:0] out_data_o,
  output wire          shutdown_o
);

  localparam [2:0] BS_IDLE    = 3'd0;
  localparam [2:0] BS_DWELL   = 3'd1;
  localparam [2:0] BS_ATTACK  = 3'd2;
  localparam [2:0] BS_HOLD    = 3'd3;
  localparam [2:0] BS_RELEASE = 3'd4;
  localparam [2:0] BS_SHUT    = 3'd5;

  // Header constants as integers, so that each use can take exactly the bits it needs.
  localparam TK_MS    = `LBG_TICKS_PER_MS;
  localparam TK_US10  = `LBG_TICKS_PER_US10;
  localparam RLS_BASE = `LBG_RLS_TICKS_BASE;
  localparam U_6DB    = `LBG_UNITS_PER_6DB;
  localparam U_FRAC   = `LBG_UNITS_PER_FRAC;
  localparam LIM_STEP = `LBG_LIM_ATK_UNITS;

  // Register select: 0..6 configuration, 7 status, 8 unmapped.
  function [3:0] reg_sel;
    input [7:0] addr;
    begin
      case (addr[7:2])
        `LBG_IDX_COMB:  reg_sel = 4'd0;
        `LBG_IDX_LIM_A: reg_sel = 4'd1;
        `LBG_IDX_LIM_B: reg_sel = 4'd2;
        `LBG_IDX_BOP_A: reg_sel = 4'd3;
        `LBG_IDX_BOP_B: reg_sel = 4'd4;
        `LBG_IDX_BOP_C: reg_sel = 4'd5;
        `LBG_IDX_BOP_D: reg_sel = 4'd6;
        `LBG_IDX_STAT:  reg_sel = 4'd7;
        default:        reg_sel = 4'd8;
      endcase
    end
  endfunction

  // Brownout step sizes in 1/16 dB units, shared by attack and release.
  function [6:0] step_units;
    input [3:0] code;
    begin
      case (code)
        4'h0:    step_units = 7'd1;
        4'h1:    step_units = 7'd8;
        4'h2:    step_units = 7'd14;
        4'h3:    step_units = 7'd21;
        4'h4:    step_units = 7'd27;
        4'h5:    step_units = 7'd33;
        4'h6:    step_units = 7'd40;
        4'h7:    step_units = 7'd46;
        4'h8:    step_units = 7'd52;
        4'h9:    step_units = 7'd59;
        4'ha:    step_units = 7'd65;
        4'hb:    step_units = 7'd71;
        4'hc:    step_units = 7'd78;
        4'hd:    step_units = 7'd84;
        4'he:    step_units = 7'd90;
        default: step_units = 7'd96;
      endcase
    end
  endfunction

  // Saturating add of a step onto an attenuation, limited by the cap.
  function [9:0] sat_add;
    input [9:0] att;
    input [6:0] step;
    input [9:0] cap;
    reg   [10:0] sum;
    begin
      sum = {1'b0, att} + {4'h0, step};
      sat_add = (sum > {1'b0, cap}) ? cap : sum[9:0];
    end
  endfunction

  reg [7:0] comb_reg, lim_a_reg, lim_b_reg, bop_a_reg, bop_b_reg, bop_c_reg, bop_d_reg;
  reg       aw_held_reg, w_held_reg;
  reg [7:0] aw_addr_reg;
  reg [7:0] w_data_reg;
  reg       w_strb_reg;
  reg [2:0] bop_state_reg;
  reg [9:0] lim_att_reg, bop_att_reg;
  reg [6:0] tick_cnt_reg;
  reg       tick_reg;
  reg [2:0] l3_sync_reg, l0_sync_reg;
  reg       l3_reg, l0_reg;
  reg       over_reg;
  reg [19:0] lim_atk_t_reg, lim_rls_t_reg, lim_hold_t_reg;
  reg [19:0] bop_t_reg;
  reg [DW-1:0] buf_mem [0:1];
  reg       wr_ptr_reg, rd_ptr_reg;
  reg [1:0] count_reg;

  wire       wr_go   = aw_held_reg && w_held_reg && !s_axi_bvalid;
  wire [3:0] wr_sel  = reg_sel(aw_addr_reg);
  wire [3:0] rd_sel  = reg_sel(s_axi_araddr);
  wire       rd_go   = s_axi_arvalid && !s_axi_rvalid;
  wire       bop_on  = bop_a_reg[`LBG_BIT_BROWNOUT_GUARD_ENABLE];
  wire       lim_on  = lim_a_reg[`LBG_BIT_PEAK_LIMIT_ENABLE];
  wire [3:0] atk_code = (lim_a_reg[4:1] > `LBG_ATK_CODE_MAX) ? `LBG_ATK_CODE_MAX : lim_a_reg[4:1];
  wire [3:0] rls_raw  = lim_b_reg[6:3];
  wire [3:0] rls_code = (rls_raw == 4'h0) ? 4'h1 : ((rls_raw > `LBG_RLS_CODE_MAX) ? `LBG_RLS_CODE_MAX : rls_raw);
  wire [4:0] dhr_code = (bop_a_reg[7:3] > `LBG_DHR_CODE_MAX) ? `LBG_DHR_CODE_MAX : bop_a_reg[7:3];
  wire [6:0] cap_code = (bop_b_reg[6:0] > `LBG_CAP_CODE_MAX) ? `LBG_CAP_CODE_MAX : bop_b_reg[6:0];
  wire [9:0] cap_units = {cap_code[5:0], 4'h0};
  wire       lim_run = lim_on && !(lim_b_reg[`LBG_BIT_LIM_PAUSE] && bop_state_reg != BS_IDLE);

  // Register bus write path.
  assign s_axi_awready = !aw_held_reg;
  assign s_axi_wready  = !w_held_reg;
  assign s_axi_arready = !s_axi_rvalid;

  always @(posedge mclk_i) begin
    if (sys_rst_i) begin
      aw_held_reg  <= 1'b0;
      w_held_reg   <= 1'b0;
      aw_addr_reg  <= 8'h00;
      w_data_reg   <= 8'h00;
      w_strb_reg   <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `LBG_RESP_OKAY;
      comb_reg     <= `LBG_RST_COMB;
      lim_a_reg    <= `LBG_RST_LIM_A;
      lim_b_reg    <= `LBG_RST_LIM_B;
      bop_a_reg    <= `LBG_RST_BOP_A;
      bop_b_reg    <= `LBG_RST_BOP_B;
      bop_c_reg    <= `LBG_RST_BOP_C;
      bop_d_reg    <= `LBG_RST_BOP_D;
    end else begin
      if (s_axi_awvalid && !aw_held_reg) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held_reg) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata[7:0];
        w_strb_reg <= s_axi_wstrb[0];
      end
      // Hold-clear is dropped by hardware one cycle after it was set; a new write wins.
      if (bop_b_reg[`LBG_BIT_HOLD_CLR]) begin
        bop_b_reg[`LBG_BIT_HOLD_CLR] <= 1'b0;
      end
      if (wr_go) begin
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_sel > 4'd7) ? `LBG_RESP_SLVERR : `LBG_RESP_OKAY;
        if (w_strb_reg) begin
          case (wr_sel)
            4'd0:    comb_reg  <= w_data_reg & `LBG_MSK_COMB;
            4'd1:    lim_a_reg <= w_data_reg & `LBG_MSK_LIM_A;
            4'd2:    lim_b_reg <= w_data_reg & `LBG_MSK_LIM_B;
            4'd3:    bop_a_reg <= w_data_reg & `LBG_MSK_BOP_A;
            4'd4:    bop_b_reg <= w_data_reg & `LBG_MSK_BOP_B;
            4'd5:    bop_c_reg <= w_data_reg & `LBG_MSK_BOP_C;
            4'd6:    bop_d_reg <= w_data_reg & `LBG_MSK_BOP_D;
            default: comb_reg  <= comb_reg;
          endcase
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Register bus read path; the status word shows live attenuation and state.
  wire [9:0] total_att;
  always @(posedge mclk_i) begin
    if (sys_rst_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `LBG_RESP_OKAY;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= (rd_sel > 4'd7) ? `LBG_RESP_SLVERR : `LBG_RESP_OKAY;
      case (rd_sel)
        4'd0:    s_axi_rdata <= {24'h000000, comb_reg};
        4'd1:    s_axi_rdata <= {24'h000000, lim_a_reg};
        4'd2:    s_axi_rdata <= {24'h000000, lim_b_reg};
        4'd3:    s_axi_rdata <= {24'h000000, bop_a_reg};
        4'd4:    s_axi_rdata <= {24'h000000, bop_b_reg};
        4'd5:    s_axi_rdata <= {24'h000000, bop_c_reg};
        4'd6:    s_axi_rdata <= {24'h000000, bop_d_reg};
        4'd7:    s_axi_rdata <= {17'h00000, (bop_state_reg == BS_SHUT), (lim_att_reg != 10'h000),
                                 bop_state_reg, total_att};
        default: s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Tick divider and brownout level synchronisers.
  always @(posedge mclk_i) begin
    if (sys_rst_i) begin
      tick_cnt_reg <= 7'h00;
      tick_reg     <= 1'b0;
      l3_sync_reg  <= 3'b000;
      l0_sync_reg  <= 3'b000;
      l3_reg       <= 1'b0;
      l0_reg       <= 1'b0;
    end else begin
      tick_reg <= (tick_cnt_reg == TICK_CYCLES[6:0] - 7'h01);
      tick_cnt_reg <= (tick_cnt_reg == TICK_CYCLES[6:0] - 7'h01) ? 7'h00 : tick_cnt_reg + 7'h01;
      l3_sync_reg <= {l3_sync_reg[1:0], bop_level3_i};
      l0_sync_reg <= {l0_sync_reg[1:0], bop_level0_i};
      if (l3_sync_reg[1] == l3_sync_reg[2]) begin
        l3_reg <= l3_sync_reg[2];
      end
      if (l0_sync_reg[1] == l0_sync_reg[2]) begin
        l0_reg <= l0_sync_reg[2];
      end
    end
  end

  // Brownout and limiter timing tables in ticks.
  reg [19:0] dwell_ticks, rate_ticks, lim_hold_ticks, lim_rls_ticks;
  always @* begin
    case (bop_c_reg[7:5])
      3'd0:    dwell_ticks = 20'd0;
      3'd1:    dwell_ticks = 20'd10 * TK_US10[19:0];
      3'd2:    dwell_ticks = 20'd25 * TK_US10[19:0];
      3'd3:    dwell_ticks = 20'd50 * TK_US10[19:0];
      3'd4:    dwell_ticks = 20'd100 * TK_US10[19:0];
      3'd5:    dwell_ticks = 20'd200 * TK_US10[19:0];
      3'd6:    dwell_ticks = 20'd400 * TK_US10[19:0];
      default: dwell_ticks = 20'd800 * TK_US10[19:0];
    endcase
    case (bop_d_reg[7:5])
      3'd0:    rate_ticks = 20'd1;
      3'd1:    rate_ticks = 20'd2;
      3'd2:    rate_ticks = 20'd4;
      3'd3:    rate_ticks = 20'd10;
      3'd4:    rate_ticks = 20'd20;
      3'd5:    rate_ticks = 20'd40;
      3'd6:    rate_ticks = 20'd100;
      default: rate_ticks = 20'd200;
    endcase
    case (lim_b_reg[2:0])
      3'd0:    lim_hold_ticks = 20'd0;
      3'd1:    lim_hold_ticks = 20'd10 * TK_MS[19:0];
      3'd2:    lim_hold_ticks = 20'd25 * TK_MS[19:0];
      3'd3:    lim_hold_ticks = 20'd50 * TK_MS[19:0];
      3'd4:    lim_hold_ticks = 20'd100 * TK_MS[19:0];
      3'd5:    lim_hold_ticks = 20'd250 * TK_MS[19:0];
      3'd6:    lim_hold_ticks = 20'd500 * TK_MS[19:0];
      default: lim_hold_ticks = 20'd1000 * TK_MS[19:0];
    endcase
    lim_rls_ticks = RLS_BASE[19:0] << (rls_code - 4'h1);
  end

  // Brownout state machine.
  always @(posedge mclk_i) begin
    if (sys_rst_i) begin
      bop_state_reg <= BS_IDLE;
      bop_att_reg   <= 10'h000;
      bop_t_reg     <= 20'h00000;
    end else if (bop_state_reg == BS_SHUT) begin
      bop_state_reg <= BS_SHUT;
    end else if (!bop_on) begin
      bop_state_reg <= BS_IDLE;
      bop_att_reg   <= 10'h000;
      bop_t_reg     <= 20'h00000;
    end else if (l0_reg) begin
      if (bop_a_reg[`LBG_BIT_BROWNOUT_LEVEL0_SHUTDOWN]) begin
        bop_state_reg <= BS_SHUT;
      end else begin
        bop_state_reg <= BS_HOLD;
        bop_att_reg   <= cap_units;
        bop_t_reg     <= BOP_HOLD_TICKS[19:0];
      end
    end else begin
      case (bop_state_reg)
        BS_IDLE: begin
          if (l3_reg) begin
            bop_state_reg <= BS_DWELL;
            bop_t_reg     <= dwell_ticks;
          end
        end
        BS_DWELL: begin
          if (!l3_reg) begin
            bop_state_reg <= BS_IDLE;
          end else if (bop_t_reg == 20'h00000) begin
            bop_state_reg <= BS_ATTACK;
          end else if (tick_reg) begin
            bop_t_reg <= bop_t_reg - 20'h00001;
          end
        end
        BS_ATTACK: begin
          if (!l3_reg) begin
            bop_state_reg <= BS_HOLD;
            bop_t_reg     <= BOP_HOLD_TICKS[19:0];
          end else if (tick_reg) begin
            if (bop_t_reg == 20'h00000) begin
              bop_att_reg <= sat_add(bop_att_reg, step_units(bop_c_reg[4:1]), cap_units);
              bop_t_reg   <= rate_ticks - 20'h00001;
            end else begin
              bop_t_reg <= bop_t_reg - 20'h00001;
            end
          end
        end
        BS_HOLD: begin
          if (l3_reg) begin
            bop_state_reg <= BS_ATTACK;
            bop_t_reg     <= 20'h00000;
          end else if (bop_b_reg[`LBG_BIT_HOLD_CLR] ||
                       (BOP_HOLD_INFINITE == 0 && bop_t_reg == 20'h00000)) begin
            bop_state_reg <= BS_RELEASE;
            bop_t_reg     <= 20'h00000;
          end else if (tick_reg && bop_t_reg != 20'h00000) begin
            bop_t_reg <= bop_t_reg - 20'h00001;
          end
        end
        BS_RELEASE: begin
          if (l3_reg) begin
            bop_state_reg <= BS_ATTACK;
            bop_t_reg     <= 20'h00000;
          end else if (bop_att_reg == 10'h000) begin
            bop_state_reg <= BS_IDLE;
          end else if (tick_reg) begin
            if (bop_t_reg == 20'h00000) begin
              bop_att_reg <= (bop_att_reg > {3'h0, step_units(bop_d_reg[4:1])}) ?
                             bop_att_reg - {3'h0, step_units(bop_d_reg[4:1])} : 10'h000;
              bop_t_reg   <= BOP_RLS_TICKS[19:0] - 20'h00001;
            end else begin
              bop_t_reg <= bop_t_reg - 20'h00001;
            end
          end
        end
        default: begin
          bop_state_reg <= BS_IDLE;
        end
      endcase
    end
  end

  // Limiter threshold: supply reference scaled by (40 + 2.5 % steps) / 40.
  wire [4:0]    dhr_eff = lim_a_reg[`LBG_BIT_LIM_DHYS] ? dhr_code : `LBG_DHR_CODE_ZERO;
  wire [DW+5:0] thr_prod = supply_peak_i * (6'd32 + {1'b0, dhr_eff});
  wire [DW+5:0] thr_full = thr_prod / 6'd40;
  wire [DW-1:0] in_mag = in_data_i[DW-1] ? (~in_data_i + 1'b1) : in_data_i;
  wire          in_take = in_valid_i && in_ready_o;

  // Limiter attack, hold and release.
  always @(posedge mclk_i) begin
    if (sys_rst_i) begin
      lim_att_reg    <= 10'h000;
      over_reg       <= 1'b0;
      lim_atk_t_reg  <= 20'h00000;
      lim_rls_t_reg  <= 20'h00000;
      lim_hold_t_reg <= 20'h00000;
    end else if (!lim_on) begin
      lim_att_reg <= 10'h000;
      over_reg    <= 1'b0;
    end else begin
      if (lim_run && tick_reg) begin
        if (over_reg) begin
          lim_hold_t_reg <= lim_hold_ticks;
          lim_rls_t_reg  <= 20'h00000;
          if (lim_atk_t_reg == 20'h00000) begin
            lim_att_reg   <= sat_add(lim_att_reg, LIM_STEP[6:0], cap_units);
            lim_atk_t_reg <= (20'h00001 << atk_code) - 20'h00001;
          end else begin
            lim_atk_t_reg <= lim_atk_t_reg - 20'h00001;
          end
        end else if (lim_hold_t_reg != 20'h00000) begin
          lim_hold_t_reg <= lim_hold_t_reg - 20'h00001;
        end else if (lim_rls_t_reg == 20'h00000) begin
          lim_att_reg   <= (lim_att_reg != 10'h000) ? lim_att_reg - 10'h001 : 10'h000;
          lim_rls_t_reg <= lim_rls_ticks - 20'h00001;
        end else begin
          lim_rls_t_reg <= lim_rls_t_reg - 20'h00001;
        end
      end
      // A peak seen in the consuming cycle survives into the next period.
      if (in_take && ({6'h00, in_mag} > thr_full)) begin
        over_reg <= 1'b1;
      end else if (lim_run && tick_reg) begin
        over_reg <= 1'b0;
      end
    end
  end

  // Combined attenuation.
  wire [10:0] att_sum = {1'b0, lim_att_reg} + {1'b0, bop_att_reg};
  wire [9:0]  att_max = (lim_att_reg > bop_att_reg) ? lim_att_reg : bop_att_reg;
  wire [10:0] att_comb = comb_reg[`LBG_BIT_COMB_MODE] ? {1'b0, att_max} : att_sum;
  assign total_att = (att_comb > {1'b0, cap_units}) ? cap_units : att_comb[9:0];

  // Gain: shift by whole 6 dB units and scale by an eighth-step mantissa.
  wire [9:0] g_quot  = total_att / U_6DB[9:0];
  wire [9:0] g_rem   = total_att % U_6DB[9:0];
  wire [9:0] g_fidx  = g_rem / U_FRAC[9:0];
  wire [3:0] g_shift = g_quot[3:0];
  wire [2:0] g_frac  = g_fidx[2:0];
  reg  [8:0] g_mant;
  always @* begin
    case (g_frac)
      3'd0:    g_mant = 9'd256;
      3'd1:    g_mant = 9'd235;
      3'd2:    g_mant = 9'd215;
      3'd3:    g_mant = 9'd197;
      3'd4:    g_mant = 9'd181;
      3'd5:    g_mant = 9'd166;
      3'd6:    g_mant = 9'd152;
      default: g_mant = 9'd140;
    endcase
  end
  wire signed [DW+9:0] g_prod = $signed(in_data_i) * $signed({1'b0, g_mant});
  wire signed [DW+9:0] g_scaled = g_prod >>> (g_shift + 4'd8);
  wire [DW-1:0] g_out = (bop_state_reg == BS_SHUT) ? {DW{1'b0}} : g_scaled[DW-1:0];

  // Two-entry output buffer; back-pressure from the receiver stalls the input.
  assign in_ready_o  = (count_reg != 2'd2);
  assign out_valid_o = (count_reg != 2'd0);
  assign out_data_o  = buf_mem[rd_ptr_reg];
  wire   out_take    = out_valid_o && out_ready_i;

  always @(posedge mclk_i) begin
    if (sys_rst_i) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg  <= 2'd0;
      buf_mem[0] <= {DW{1'b0}};
      buf_mem[1] <= {DW{1'b0}};
    end else begin
      if (in_take) begin
        buf_mem[wr_ptr_reg] <= g_out;
        wr_ptr_reg          <= ~wr_ptr_reg;
      end
      if (out_take) begin
        rd_ptr_reg <= ~rd_ptr_reg;
      end
      if (in_take && !out_take) begin
        count_reg <= count_reg + 2'd1;
      end else if (out_take && !in_take) begin
        count_reg <= count_reg - 2'd1;
      end
    end
  end

  assign shutdown_o = (bop_state_reg == BS_SHUT);

endmodule // lbg_gain_ctrl
`default_nettype wire

// ### lbg_gain_ctrl_sva.sv
// Bus, stream and shutdown assertions for the gain-control block.
`timescale 1ns/1ns
`default_nettype none
module lbg_gain_ctrl_sva #(
  parameter DW = 24
) (
  input wire logic          mclk_i,
  input wire logic          sys_rst_i,
  input wire logic          s_axi_awvalid,
  input wire logic          s_axi_awready,
  input wire logic          s_axi_wvalid,
  input wire logic          s_axi_wready,
  input wire logic          s_axi_bvalid,
  input wire logic          s_axi_bready,
  input wire logic          s_axi_arvalid,
  input wire logic          s_axi_arready,
  input wire logic          s_axi_rvalid,
  input wire logic          s_axi_rready,
  input wire logic          bop_level0_i,
  input wire logic          in_valid_i,
  input wire logic          in_ready_o,
  input wire logic          out_valid_o,
  input wire logic          out_ready_i,
  input wire logic [DW-1:0] out_data_o,
  input wire logic          shutdown_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid) else $error("rvalid dropped");
  rd_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("rvalid stuck");
  rd_latency_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read late");
  wr_latency_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid
    |-> ##2 s_axi_bvalid) else $error("write late");
  out_hold_a: assert property (out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_data_o))
    else $error("sample not held");
  in_latency_a: assert property (in_valid_i && in_ready_o |=> out_valid_o) else $error("sample lost");
  shut_sticky_a: assert property (shutdown_o |=> shutdown_o) else $error("shutdown released");
  shut_cause_a: assert property (!bop_level0_i [*7] ##0 !shutdown_o |=> !shutdown_o)
    else $error("shutdown without level 0");
  cover property (s_axi_rvalid && s_axi_rready);
  cover property (in_valid_i && !in_ready_o);
  cover property (shutdown_o);
endmodule // lbg_gain_ctrl_sva
bind lbg_gain_ctrl lbg_gain_ctrl_sva #(.DW(DW)) lbg_gain_ctrl_sva_i (.mclk_i, .sys_rst_i, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .bop_level0_i, .in_valid_i, .in_ready_o, .out_valid_o, .out_ready_i,
  .out_data_o, .shutdown_o);
`default_nettype wire

// ### tb_lbg_gain_ctrl.sv
// Self-checking bench for the gain-control block.
`timescale 1ns/1ns
`default_nettype none
module tb_lbg_gain_ctrl;
  logic        mclk_i = 0, sys_rst_i = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0, bop_level3_i = 0, bop_level0_i = 0;
  logic        in_valid_i = 0, out_ready_i = 1;
  logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0;
  logic [22:0] supply_peak_i = 0;
  logic [23:0] in_data_i = 0;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire         in_ready_o, out_valid_o, shutdown_o;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  wire  [23:0] out_data_o;
  int          seed = 32'h3f05, miscompares = 0, total_checks = 0, n;
  logic [33:0] rq[$], bq[$], sq[$];
  localparam logic [7:0] AD[7] = '{8'h64, 8'h6c, 8'h70, 8'h74, 8'h78, 8'h7c, 8'h80};
  localparam logic [7:0] RS[7] = '{8'h00, 8'h22, 8'h32, 8'h40, 8'h32, 8'h02, 8'h06};
  localparam logic [7:0] WV[7] = '{8'hff, 8'hf9, 8'he7, 8'h87, 8'hff, 8'hff, 8'hff};
  localparam logic [7:0] EX[7] = '{8'h20, 8'h39, 8'he7, 8'h83, 8'h7f, 8'hfe, 8'hfe};
  lbg_gain_ctrl #(.TICK_CYCLES(2), .BOP_HOLD_TICKS(4), .BOP_RLS_TICKS(4)) lbg_gain_ctrl_i (
    .mclk_i, .sys_rst_i, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
    .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
    .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .bop_level3_i,
    .bop_level0_i, .supply_peak_i, .in_valid_i, .in_ready_o, .in_data_i, .out_valid_o, .out_ready_i,
    .out_data_o, .shutdown_o);
  initial forever #10 mclk_i = ~mclk_i;
  always @(posedge mclk_i) begin
    if (s_axi_bvalid && s_axi_bready) chk({s_axi_bresp, 32'h0}, bq.pop_front());
    if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, rq.pop_front());
    if (out_valid_o && out_ready_i) chk({10'h0, out_data_o}, sq.pop_front());
  end
  task automatic chk(input logic [33:0] s, e);
    total_checks++;
    if (s !== e) begin
      miscompares++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic end_of_test;
    if (miscompares == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic lim(input int k);
    if (k >= 4000) begin
      miscompares++;
      end_of_test();
    end
  endtask
  // One register access; address and data channels are released as each is taken.
  task automatic axi(input logic w, input logic [7:0] a, d, input logic [33:0] e);
    int k;
    @(posedge mclk_i);
    if (w) bq.push_back(e);
    else rq.push_back(e);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= w;
    s_axi_wvalid <= w;
    s_axi_bready <= w;
    s_axi_arvalid <= !w;
    s_axi_rready <= !w;
    k = 0;
    do begin
      @(posedge mclk_i);
      k++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!(w ? s_axi_bvalid : s_axi_rvalid) && k < 4000);
    lim(k);
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
  endtask
  // Streams random samples while the receiver stalls at random, then drains; each 6 dB halves a sample.
  task automatic snd(input int c, input logic m, input int sh = 0);
    logic [23:0] d, x;
    int k;
    k = 0;
    repeat (c) begin
      d = $random(seed);
      x = $signed(d) >>> sh;
      sq.push_back(m ? 34'h0 : {10'h0, x});
      in_data_i <= d;
      supply_peak_i <= $random(seed);
      in_valid_i <= 1'b1;
      do begin
        out_ready_i <= $random(seed);
        @(posedge mclk_i);
        k++;
      end while (!in_ready_o && k < 4000);
    end
    in_valid_i <= 1'b0;
    out_ready_i <= 1'b1;
    while (sq.size() != 0 && k < 4000) begin
      @(posedge mclk_i);
      k++;
    end
    lim(k);
  endtask
  task automatic lvl(input logic v);
    bop_level0_i <= v;
    bop_level3_i <= v;
    repeat (20) @(posedge mclk_i);
  endtask
  initial begin
    repeat (3) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    foreach (AD[i]) axi(0, AD[i], 0, {26'h0, RS[i]});
    foreach (AD[i]) axi(1, AD[i], WV[i], 34'h0);
    foreach (AD[i]) axi(0, AD[i], 0, {26'h0, EX[i]});
    axi(0, 8'h00, 0, {2'b10, 32'h0});
    axi(1, 8'h00, 8'hff, {2'b10, 32'h0});
    axi(1, 8'h6c, 8'h20, 34'h0);
    axi(1, 8'h74, 8'h42, 34'h0);
    lvl(1);
    snd(40, 0);
    chk(shutdown_o, 0);
    lvl(0);
    axi(1, 8'h78, 8'h00, 34'h0);
    axi(1, 8'h74, 8'h41, 34'h0);
    lvl(1);
    snd(40, 0);
    chk(shutdown_o, 0);
    lvl(0);
    // Level 3 alone: a 100 us dwell, then one 6 dB attack step that stands for 500 us.
    axi(1, 8'h78, 8'h2e, 34'h0);
    axi(1, 8'h7c, 8'h3e, 34'h0);
    axi(1, 8'h80, 8'he0, 34'h0);
    bop_level3_i <= 1'b1;
    repeat (20) @(posedge mclk_i);
    axi(0, 8'hf0, 0, 34'h400);
    repeat (100) @(posedge mclk_i);
    axi(0, 8'hf0, 0, 34'h860);
    snd(12, 0, 1);
    axi(1, 8'h74, 8'h43, 34'h0);
    lvl(1);
    for (n = 0; n < 500 && shutdown_o !== 1'b1; n++) @(posedge mclk_i);
    chk(shutdown_o, 1);
    snd(20, 1);
    end_of_test();
  end
endmodule // tb_lbg_gain_ctrl
`default_nettype wire
